// ==== dv/vdc_command_port_monitor.sv ====
// Concurrent checks on the ports of the video decoder command port.
`include "vdc_defs.svh"
`default_nettype none
module vdc_command_port_monitor (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic mmio_wr,
	input wire logic mmio_rd,
	input wire logic [15:0] mmio_addr,
	input wire logic [31:0] mmio_wdata,
	input wire logic [31:0] mmio_rdata,
	input wire logic flip_done,
	input wire logic mc_busy,
	input wire logic block_valid,
	input wire logic [5:0] block_index,
	input wire logic params_ready,
	input wire vdc_pkg::vdc_mbtype_s mb_type,
	input wire logic [31:0] mb_position,
	input wire logic [31:0] mv_word_one,
	input wire logic [31:0] mv_word_three,
	input wire logic [31:0] mv_word_four
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// Port properties
	// ************************************************************
	// One clock domain, so clock and reset are declared once for all checks.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	property p_type_store;
		mmio_wr && mmio_addr == `VDC_MB_TYPE |=> {mb_type} == $past(mmio_wdata);
	endproperty
	a_type_store: assert property (p_type_store) else $error("type word not stored");
	property p_pos_store;
		mmio_wr && mmio_addr == `VDC_MB_POS |=> mb_position == $past(mmio_wdata);
	endproperty
	a_pos_store: assert property (p_pos_store) else $error("position not stored");
	property p_mv_one;
		mmio_wr && mmio_addr == `VDC_MV0 |=> mv_word_one == $past(mmio_wdata);
	endproperty
	a_mv_one: assert property (p_mv_one) else $error("vector one not stored");
	property p_mv_three;
		mmio_wr && mmio_addr == `VDC_MV2 |=> mv_word_three == $past(mmio_wdata);
	endproperty
	a_mv_three: assert property (p_mv_three) else $error("vector three not stored");
	property p_mv_four;
		mmio_wr && mmio_addr == `VDC_MV3 |=> mv_word_four == $past(mmio_wdata);
	endproperty
	a_mv_four: assert property (p_mv_four) else $error("vector four not stored");
	// A flip wait must raise busy; the same-cycle flip pulse is left out on purpose.
	property p_flip_wait;
		mmio_wr && mmio_addr == `VDC_MB_TYPE && mmio_wdata[7] && !flip_done |=> mc_busy;
	endproperty
	a_flip_wait: assert property (p_flip_wait) else $error("flip wait not raised");
	property p_param_release;
		mmio_wr && mmio_addr == `VDC_END_PARAM && !mc_busy |=> params_ready ##1 !params_ready;
	endproperty
	a_param_release: assert property (p_param_release) else $error("parameter release late");
	property p_block_run;
		mmio_wr && mmio_addr == `VDC_END_BLOCK |-> ##2 (block_valid && block_index == 6'h00)
			##63 (block_valid && block_index == 6'h3F) ##1 !block_valid;
	endproperty
	a_block_run: assert property (p_block_run) else $error("block output run wrong");
	property p_status_word;
		mmio_rd && mmio_addr == `VDC_STATUS |=> mmio_rdata[31:19] == 13'h0000
			&& (mmio_rdata[15:0] == 16'h0002 || mmio_rdata[15:0] == 16'h0000);
	endproperty
	a_status_word: assert property (p_status_word) else $error("status word malformed");
endmodule // vdc_command_port_monitor
`default_nettype wire

// ==== dv/vdc_command_port_tb.sv ====
// Directed testbench of the video decoder command port.
`include "vdc_defs.svh"
`default_nettype none
module vdc_command_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// Signals, design and tasks
	// ************************************************************
	logic sys_clk, reset_n, mmio_wr, mmio_rd, coeff_packing_select, flip_done;
	logic mc_busy, block_valid, params_ready;
	logic [15:0] mmio_addr;
	logic [31:0] mmio_wdata, mmio_rdata, mb_position, rv;
	logic [31:0] mv_word_one, mv_word_two, mv_word_three, mv_word_four;
	logic [5:0] block_index;
	logic [11:0] block_coeff;
	vdc_pkg::vdc_mbtype_s mb_type;
	logic [11:0] exp_blk [64];
	logic [15:0] offs [6];
	logic [31:0] vals [6];
	int miscompares, n_compared, i, k, lat;
	vdc_command_port u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .mmio_wr(mmio_wr),
		.mmio_rd(mmio_rd), .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata),
		.mmio_rdata(mmio_rdata), .coeff_packing_select(coeff_packing_select),
		.flip_done(flip_done), .mc_busy(mc_busy), .block_valid(block_valid),
		.block_index(block_index), .block_coeff(block_coeff), .params_ready(params_ready),
		.mb_type(mb_type), .mb_position(mb_position), .mv_word_one(mv_word_one),
		.mv_word_two(mv_word_two), .mv_word_three(mv_word_three), .mv_word_four(mv_word_four));
	// Free-running 40 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Bus tasks start and end just after an edge; the strobe lasts one cycle.
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		mmio_addr = a;
		mmio_wdata = d;
		mmio_wr = 1'b1;
		@(posedge sys_clk);
		#2 mmio_wr = 1'b0;
		@(posedge sys_clk);
		#2;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		mmio_addr = a;
		mmio_rd = 1'b1;
		@(posedge sys_clk);
		#2 mmio_rd = 1'b0;
		d = mmio_rdata;
		@(posedge sys_clk);
		#2;
	endtask
	// Ends a block and compares all sixty-four flushed slots against the model.
	task automatic flush();
		int got;
		got = 0;
		repeat (4) @(posedge sys_clk);
		#2 mmio_addr = `VDC_END_BLOCK;
		mmio_wr = 1'b1;
		@(posedge sys_clk);
		#2 mmio_wr = 1'b0;
		for (k = 0; k < 80; k++) begin
			@(posedge sys_clk);
			#2;
			if (block_valid === 1'b1) begin
				got++;
				chk({20'h0, block_coeff}, {20'h0, exp_blk[block_index]});
			end
		end
		chk(32'(got), 32'd64);
		foreach (exp_blk[j]) exp_blk[j] = 12'h000;
	endtask
	// Ends the parameter set and counts cycles to the release, with an optional flip.
	task automatic param(input logic flip);
		mmio_addr = `VDC_END_PARAM;
		mmio_wr = 1'b1;
		@(posedge sys_clk);
		#2 mmio_wr = 1'b0;
		for (k = 1; k <= 20 && params_ready !== 1'b1; k++) begin
			flip_done = flip && k == 4;
			@(posedge sys_clk);
			#2;
		end
		flip_done = 1'b0;
		lat = k;
		if (k > 20) begin
			miscompares++;
			wrap_up();
		end
	endtask
	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		{reset_n, mmio_wr, mmio_rd, coeff_packing_select, flip_done} = 5'h00;
		mmio_addr = 16'h0000;
		mmio_wdata = 32'h0000_0000;
		foreach (exp_blk[j]) exp_blk[j] = 12'h000;
		offs = '{`VDC_MB_TYPE, `VDC_MB_POS, `VDC_MV0, `VDC_MV1, `VDC_MV2, `VDC_MV3};
		vals = '{32'h9A3F_6E45, 32'h0015_0C2A, 32'h83FF_8FFF, 32'h0155_0AAA, 32'h82AA_8555,
			32'h0001_0C01};
		repeat (2) @(posedge sys_clk);
		#2 reset_n = 1'b1;
		for (i = 0; i < 6; i++) begin
			rd(offs[i], rv);
			chk(rv, `VDC_RESET_WORD);
		end
		rd(`VDC_STATUS, rv);
		chk(rv, 32'h0001_0002);
		wr(`VDC_STATUS, 32'hFFFF_FFFF);
		rd(`VDC_STATUS, rv);
		chk(rv, 32'h0001_0002);
		for (i = 0; i < 6; i++) wr(offs[i], vals[i]);
		for (i = 0; i < 6; i++) begin
			rd(offs[i], rv);
			chk(rv, vals[i]);
		end
		chk({15'h0, mb_type.subpix_d, mb_type.subpix_a, mb_type.comp_mode, mb_type.last_mb,
			mb_type.coded_mask}, {15'h0, 4'h9, 4'hF, 2'h2, 1'h1, 6'h05});
		chk(mv_word_two, vals[3]);
		rd(`VDC_END_PARAM, rv);
		chk(rv, 32'h0000_0000);
		$display("test registers done");
		// Reserved bits are set in the third word to prove they are ignored.
		wr(`VDC_COEF_HI, 32'h0002_0805);
		wr(`VDC_COEF_LO, 32'h0000_0123);
		wr(16'h8680, 32'hFFC1_F7FF);
		exp_blk[2] = 12'h805;
		exp_blk[3] = 12'h123;
		exp_blk[5] = 12'h7FF;
		flush();
		$display("test single format done");
		coeff_packing_select = 1'b1;
		wr(`VDC_COEF_LO, 32'h00FE_03FF);
		wr(`VDC_COEF_LO, 32'h07FF_8400);
		wr(`VDC_COEF_LO, 32'hFFFF_0100);
		// Format 11 places its low value alone, with no second pair.
		wr(`VDC_COEF_LO, 32'h8000_8003);
		exp_blk[1] = 12'hFFF;
		exp_blk[2] = 12'h0FE;
		exp_blk[5] = 12'h7FF;
		exp_blk[6] = 12'hF00;
		exp_blk[7] = 12'h003;
		flush();
		coeff_packing_select = 1'b0;
		$display("test pair formats done");
		wr(`VDC_MB_TYPE, 32'h0000_0080);
		chk({31'h0, mc_busy}, 32'h1);
		param(1'b1);
		chk(32'(lat), 32'd5);
		chk({31'h0, mc_busy}, 32'h0);
		wr(`VDC_MB_TYPE, 32'h0000_0000);
		param(1'b0);
		chk(32'(lat), 32'd1);
		$display("test parameter release done");
		wrap_up();
	end
endmodule // vdc_command_port_tb
bind vdc_command_port vdc_command_port_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
	.mmio_wr(mmio_wr), .mmio_rd(mmio_rd), .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata),
	.mmio_rdata(mmio_rdata), .flip_done(flip_done), .mc_busy(mc_busy),
	.block_valid(block_valid), .block_index(block_index), .params_ready(params_ready),
	.mb_type(mb_type), .mb_position(mb_position), .mv_word_one(mv_word_one),
	.mv_word_three(mv_word_three), .mv_word_four(mv_word_four));
`default_nettype wire

// ==== src/vdc_block_mem.sv ====
// Sixty-four coefficient store of one 8x8 block with registered read data.
`default_nettype none
module vdc_block_mem (
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic [11:0] wr_data,
	input wire logic [5:0] rd_addr,
	output logic [11:0] rd_data
);
	logic [11:0] mem [0:63];

	// Plain synchronous RAM; contents need no reset since the port's fill mask zeroes slots never written.
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : vdc_block_mem
`default_nettype wire

// ==== src/vdc_command_port.sv ====
// Memory-mapped command port of the transform and motion-compensation engine.
`include "vdc_defs.svh"
`default_nettype none

// Functional notes
// - Any offset 8600h..86FFh is a coefficient write.
// - Packing 0: 12-bit value bits 11..0, run bits 21..16.
// - Packing 1: pair format from bit 31 (high) and bit 15 (low).
// - Format 00: two 9-bit value/6-bit run pairs, low pair first.
// - Format 01: one pair, run 14..9, 12-bit value 27..16.
// - Format 10: one pair, 9-bit value 8..0, run 14..9.
// - Type word holds four sub-pixel nibbles, bits 19..16 to 31..28.
// - Type bit 15 selects bottom field; host writes 0 for MPEG-1.
// - Type bit 14 selects field DCT; host rules per picture kind.
// - Type bits 13..12 select compensation mode.
// - Bit 11 picture kind, bit 10 backward, bit 9 forward.
// - Type bit 7 holds the macroblock until page flip completes.
// - Type bit 6 marks last macroblock; bit 8 marks intra.
// - Coded block mask bits 5..0: luma 0..3, Cb, Cr.
// - Position word: X 5..0, Y 21..16, destination buffer 11..10.
// - Vector word: X 9..0, Y 25..16, reference buffer 11..10.
// - Second and third vectors share the first vector layout.
// - Fourth vector word at 8714h with the same layout.
// - Write to 8718h only ends the parameter set.
// - Write to 871Ch ends one 8x8 block.
// - Status at 8758h: MC busy 18, transform busy 17, idle 16, free queue.
module vdc_command_port (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic mmio_wr,
	input wire logic mmio_rd,
	input wire logic [15:0] mmio_addr,
	input wire logic [31:0] mmio_wdata,
	output logic [31:0] mmio_rdata,
	input wire logic coeff_packing_select,
	input wire logic flip_done,
	output logic mc_busy,
	output logic block_valid,
	output logic [5:0] block_index,
	output logic [11:0] block_coeff,
	output logic params_ready,
	output vdc_pkg::vdc_mbtype_s mb_type,
	output logic [31:0] mb_position,
	output logic [31:0] mv_word_one,
	output logic [31:0] mv_word_two,
	output logic [31:0] mv_word_three,
	output logic [31:0] mv_word_four
);
	// ************************************************************
	// Register state
	// ************************************************************
	// Port state outside the pair buffer and block store lives in one record: one comb process builds the
	// next copy and one clocked process registers it. The stored words keep
	// all 32 bits written, reserved bits included, so a read returns exactly
	// what the host wrote.
	typedef struct packed {
		vdc_pkg::vdc_state_e fsm;
		logic [31:0] coef;
		logic [31:0] mbtype;
		logic [31:0] mbpos;
		logic [31:0] mv0;
		logic [31:0] mv1;
		logic [31:0] mv2;
		logic [31:0] mv3;
		logic [6:0] pos;
		logic [6:0] rd_pos;
		logic rd_valid;
		logic [5:0] rd_idx;
		logic [63:0] filled;
		logic second_pending;
		vdc_pkg::vdc_pair_s second;
		logic end_pending;
		logic mc_wait;
		logic params_pulse;
		logic [31:0] rdata;
	} vdc_top_s;

	vdc_top_s state_reg;
	vdc_top_s state_next;

	// ************************************************************
	// Address decode and coefficient unpacking
	// ************************************************************
	logic coef_hit;
	logic end_block_hit;
	logic [1:0] pair_fmt;
	logic unpack_valid;
	logic unpack_ready;
	vdc_pkg::vdc_pair_s unpack_pair;
	vdc_pkg::vdc_pair_s head_pair;
	logic head_valid;
	logic head_ready;
	logic [11:0] mem_rd_data;
	logic [6:0] target;
	logic mem_wr;
	logic [5:0] mem_rd_addr;
	vdc_pkg::vdc_mv_s mv_view;

	// Decode of the coefficient window and the block marker; the pair format
	// comes from the two flag bits of the written word.
	assign coef_hit = mmio_wr && (mmio_addr >= `VDC_COEF_LO) && (mmio_addr <= `VDC_COEF_HI);
	assign end_block_hit = mmio_wr && (mmio_addr == `VDC_END_BLOCK);
	assign pair_fmt = {mmio_wdata[31], mmio_wdata[15]};

	// The first pair of a write goes straight into the buffer; a second pair
	// of format 00 waits one cycle in a holding slot. Writes arriving while
	// the buffer is full are dropped, so the host must watch the free count.
	always_comb begin
		unpack_valid = 1'b0;
		unpack_pair = '0;
		if (state_reg.second_pending) begin
			unpack_valid = 1'b1;
			unpack_pair = state_reg.second;
		end else if (coef_hit) begin
			unpack_valid = 1'b1;
			if (!coeff_packing_select) begin
				unpack_pair.value = mmio_wdata[11:0];
				unpack_pair.run = mmio_wdata[21:16];
			end else begin
				unpack_pair.run = mmio_wdata[14:9];
				case (pair_fmt)
					2'b01: unpack_pair.value = mmio_wdata[27:16];
					2'b10: unpack_pair.value = {{3{mmio_wdata[8]}}, mmio_wdata[8:0]};
					default: unpack_pair.value = {{3{mmio_wdata[8]}}, mmio_wdata[8:0]};
				endcase
			end
		end
	end

	// The buffer decouples the bus from placement: a flush stalls the head
	// while one more pair still enters behind it, filling both slots.
	vdc_pair_buf u_buf (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_valid(unpack_valid),
		.in_ready(unpack_ready),
		.in_data(unpack_pair),
		.out_valid(head_valid),
		.out_ready(head_ready),
		.out_data(head_pair)
	);

	// ************************************************************
	// Block store: run expansion and flush
	// ************************************************************
	// Target position of the head pair; pairs that land past the last slot
	// still pop, so a bad run cannot stall the stream.
	assign target = state_reg.pos + {1'b0, head_pair.run};
	assign head_ready = (state_reg.fsm != vdc_pkg::VDC_FLUSH);
	assign mem_wr = head_valid && head_ready && (target < `VDC_BLOCK_LEN);
	assign mem_rd_addr = state_reg.rd_pos[5:0];

	// The store is written at the run-expanded position; flush reads come
	// out one cycle later from the memory's output register.
	vdc_block_mem u_mem (
		.sys_clk(sys_clk),
		.wr_en(mem_wr),
		.wr_addr(target[5:0]),
		.wr_data(head_pair.value),
		.rd_addr(mem_rd_addr),
		.rd_data(mem_rd_data)
	);

	// Vector one reads back through its field view, which pins down the layout.
	assign mv_view = vdc_pkg::vdc_mv_s'(state_reg.mv0);

	// ************************************************************
	// Coefficient placement
	// ************************************************************
	// A pair is placed whenever the head pops, in idle as well as in fill.
	// The first pair of a block pops in the very cycle that leaves idle,
	// so placing only in fill would drop it.
	logic place_fire;
	logic [6:0] pos_after;
	assign place_fire = head_valid && head_ready;
	// The position saturates at the block end, so runs past the last slot
	// keep being discarded instead of wrapping back into the block.
	assign pos_after = (target < `VDC_BLOCK_LEN) ? (target + 7'd1) : `VDC_BLOCK_LEN;

	// ************************************************************
	// Status word
	// ************************************************************
	// Built from registered state apart from the read mux, so a read shows
	// the port as it stood at the edge that takes the strobe.
	logic mc_pending;
	logic xf_busy;
	logic dec_idle;
	logic [15:0] free_len;
	logic [31:0] status_word;
	assign mc_pending = state_reg.mc_wait || state_reg.end_pending;
	assign xf_busy = (state_reg.fsm != vdc_pkg::VDC_IDLE);
	assign dec_idle = !xf_busy && !head_valid && !mc_pending;
	// Only room or no room is known, so the free count reads full depth or zero.
	assign free_len = unpack_ready ? `VDC_QUEUE_DEPTH : 16'h0000;

	// Reserved bits 31..19 read zero.
	always_comb begin
		status_word = '0;
		status_word[`VDC_ST_MC_BIT] = mc_pending;
		status_word[`VDC_ST_XF_BIT] = xf_busy;
		status_word[`VDC_ST_IDLE_BIT] = dec_idle;
		status_word[15:0] = free_len;
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		state_next.params_pulse = 1'b0;
		state_next.rd_valid = 1'b0;
		// Second pair of a format 00 write is held for one cycle.
		state_next.second_pending = 1'b0;
		if (coef_hit && coeff_packing_select && (pair_fmt == 2'b00)
			&& !state_reg.second_pending) begin
			state_next.second_pending = 1'b1;
			state_next.second.run = mmio_wdata[30:25];
			state_next.second.value = {{3{mmio_wdata[24]}}, mmio_wdata[24:16]};
		end
		if (coef_hit) begin
			state_next.coef = mmio_wdata;
		end
		if (mmio_wr) begin
			case (mmio_addr)
				`VDC_MB_TYPE: begin
					state_next.mbtype = mmio_wdata;
					state_next.mc_wait = mmio_wdata[7];
				end
				`VDC_MB_POS: state_next.mbpos = mmio_wdata;
				`VDC_MV0: state_next.mv0 = mmio_wdata;
				`VDC_MV1: state_next.mv1 = mmio_wdata;
				`VDC_MV2: state_next.mv2 = mmio_wdata;
				`VDC_MV3: state_next.mv3 = mmio_wdata;
				default: ;
			endcase
		end
		// The parameter set closes on the marker; a pending page flip wait
		// defers the release until the flip completion pulse arrives.
		if (mmio_wr && (mmio_addr == `VDC_END_PARAM)) begin
			state_next.end_pending = 1'b1;
		end
		if (flip_done) begin
			state_next.mc_wait = 1'b0;
		end
		if (state_next.end_pending && !state_next.mc_wait) begin
			state_next.end_pending = 1'b0;
			state_next.params_pulse = 1'b1;
		end
		// Placement runs ahead of the sequencer; head_ready keeps it out of a flush.
		if (place_fire) begin
			if (mem_wr) begin
				state_next.filled[target[5:0]] = 1'b1;
			end
			state_next.pos = pos_after;
		end
		// Block fill and flush sequencing.
		case (state_reg.fsm)
			vdc_pkg::VDC_IDLE: begin
				if (head_valid) begin
					state_next.fsm = vdc_pkg::VDC_FILL;
				end
			end
			vdc_pkg::VDC_FILL: begin
				if (end_block_hit) begin
					state_next.fsm = vdc_pkg::VDC_FLUSH;
					state_next.rd_pos = '0;
				end
			end
			// A flush walks the read pointer over all sixty-four slots, one per
			// cycle, then returns to idle with position and fill mask cleared.
			vdc_pkg::VDC_FLUSH: begin
				if (state_reg.rd_pos < `VDC_BLOCK_LEN) begin
					state_next.rd_pos = state_reg.rd_pos + 7'd1;
					state_next.rd_valid = 1'b1;
					state_next.rd_idx = state_reg.rd_pos[5:0];
				end else begin
					state_next.fsm = vdc_pkg::VDC_IDLE;
					state_next.pos = '0;
					state_next.filled = '0;
				end
			end
			default: state_next.fsm = vdc_pkg::VDC_IDLE;
		endcase
		if (end_block_hit && (state_reg.fsm == vdc_pkg::VDC_IDLE)) begin
			state_next.fsm = vdc_pkg::VDC_FLUSH;
			state_next.rd_pos = '0;
		end
		// Read mux; unmapped offsets read zero.
		state_next.rdata = '0;
		if (mmio_rd) begin
			case (mmio_addr)
				`VDC_MB_TYPE: state_next.rdata = state_reg.mbtype;
				`VDC_MB_POS: state_next.rdata = state_reg.mbpos;
				`VDC_MV0: state_next.rdata = mv_view;
				`VDC_MV1: state_next.rdata = state_reg.mv1;
				`VDC_MV2: state_next.rdata = state_reg.mv2;
				`VDC_MV3: state_next.rdata = state_reg.mv3;
				`VDC_STATUS: state_next.rdata = status_word;
				default: begin
					if ((mmio_addr >= `VDC_COEF_LO) && (mmio_addr <= `VDC_COEF_HI)) begin
						state_next.rdata = state_reg.coef;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Asynchronous clear to zero, with the sequencer parked in idle.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.fsm <= vdc_pkg::VDC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Positions never written flush out as zero without clearing the RAM.
	logic [5:0] flush_idx_q;
	assign flush_idx_q = state_reg.rd_idx;
	assign block_valid = state_reg.rd_valid;
	assign block_index = flush_idx_q;
	assign block_coeff = state_reg.filled[flush_idx_q] ? mem_rd_data : 12'h000;
	assign mmio_rdata = state_reg.rdata;
	assign params_ready = state_reg.params_pulse;
	assign mc_busy = state_reg.mc_wait;
	assign mb_type = vdc_pkg::vdc_mbtype_s'(state_reg.mbtype);
	// Stored parameter words go out as registered, for the downstream engine.
	assign mb_position = state_reg.mbpos;
	assign mv_word_one = state_reg.mv0;
	assign mv_word_two = state_reg.mv1;
	assign mv_word_three = state_reg.mv2;
	assign mv_word_four = state_reg.mv3;
endmodule : vdc_command_port
`default_nettype wire

// ==== src/vdc_defs.svh ====
// Offsets, field positions, reset values and counts of the video decoder command port.
`ifndef VDC_DEFS_SVH
`define VDC_DEFS_SVH
`define VDC_COEF_LO 16'h8600
`define VDC_COEF_HI 16'h86FF
`define VDC_MB_TYPE 16'h8700
`define VDC_MB_POS 16'h8704
`define VDC_MV0 16'h8708
`define VDC_MV1 16'h870C
`define VDC_MV2 16'h8710
`define VDC_MV3 16'h8714
`define VDC_END_PARAM 16'h8718
`define VDC_END_BLOCK 16'h871C
`define VDC_STATUS 16'h8758
`define VDC_RESET_WORD 32'h0000_0000
`define VDC_ST_MC_BIT 18
`define VDC_ST_XF_BIT 17
`define VDC_ST_IDLE_BIT 16
`define VDC_BLOCK_LEN 7'h40
`define VDC_QUEUE_DEPTH 16'h0002
`endif

// ==== src/vdc_pair_buf.sv ====
// Two-entry buffer for run/value pairs between unpacker and block store.
`default_nettype none
module vdc_pair_buf (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire vdc_pkg::vdc_pair_s in_data,
	output logic out_valid,
	input wire logic out_ready,
	output vdc_pkg::vdc_pair_s out_data
);
	typedef struct packed {
		vdc_pkg::vdc_pair_s [1:0] slot;
		logic [1:0] count;
	} vdc_buf_s;

	vdc_buf_s state_reg;
	vdc_buf_s state_next;

	// Slot 0 is always the head; a pop shifts slot 1 down.
	always_comb begin
		state_next = state_reg;
		if (out_valid && out_ready) begin
			state_next.slot[0] = state_reg.slot[1];
			state_next.count = state_reg.count - 2'd1;
		end
		if (in_valid && in_ready) begin
			state_next.slot[state_next.count[0]] = in_data;
			state_next.count = state_next.count + 2'd1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign in_ready = (state_reg.count != 2'd2);
	assign out_valid = (state_reg.count != 2'd0);
	assign out_data = state_reg.slot[0];
endmodule : vdc_pair_buf
`default_nettype wire

// ==== src/vdc_pkg.sv ====
// Types shared by the video decoder command port.
`default_nettype none
package vdc_pkg;
	// One coefficient placed into the block store.
	typedef struct packed {
		logic [5:0] run;
		logic [11:0] value;
	} vdc_pair_s;

	// Motion vector word fields, identical for all four vectors.
	typedef struct packed {
		logic chroma_add_y;
		logic [4:0] rsvd_hi;
		logic [9:0] y_offset;
		logic chroma_add_x;
		logic [2:0] rsvd_lo;
		logic [1:0] ref_buffer;
		logic [9:0] x_offset;
	} vdc_mv_s;

	// Macroblock type word fields.
	typedef struct packed {
		logic [3:0] subpix_d;
		logic [3:0] subpix_c;
		logic [3:0] subpix_b;
		logic [3:0] subpix_a;
		logic bottom_field;
		logic field_dct;
		logic [1:0] comp_mode;
		logic frame_picture;
		logic backward;
		logic forward;
		logic intra;
		logic wait_flip;
		logic last_mb;
		logic [5:0] coded_mask;
	} vdc_mbtype_s;

	typedef enum logic [2:0] {
		VDC_IDLE = 3'b001,
		VDC_FILL = 3'b010,
		VDC_FLUSH = 3'b100
	} vdc_state_e;
endpackage : vdc_pkg
`default_nettype wire
